// ==== hw/frr_params.svh ====
`ifndef FRR_PARAMS_SVH
`define FRR_PARAMS_SVH
`define FRR_CMD_OC_LIMIT   8'h46
`define FRR_CMD_UV_REACT   8'h45
`define FRR_CMD_UNIT       8'hD2
`define FRR_RESP_MSB       7
`define FRR_RESP_LSB       6
`define FRR_RETRY_MSB      5
`define FRR_RETRY_LSB      3
`define FRR_DELAY_MSB      2
`define FRR_DELAY_LSB      0
`define FRR_RETRY_FOREVER  3'h7
`define FRR_UV_REACT_RST   8'h80
`define FRR_OC_LIMIT_RST   16'h0000
`define FRR_UNIT_RST       16'h0001
`define FRR_UNIT_NS        1000
`define FRR_CLK_NS         8
`define FRR_UNIT_CYC       ((`FRR_UNIT_NS + `FRR_CLK_NS - 1) / `FRR_CLK_NS)
`endif

// ==== hw/frr_pkg.sv ====
package frr_pkg;
  typedef enum logic [1:0] {
    FRR_RESP_IGNORE   = 2'b00,
    FRR_RESP_CONTINUE = 2'b01,
    FRR_RESP_SHUTDOWN = 2'b10,
    FRR_RESP_HOLD     = 2'b11
  } frr_resp_e;
  typedef enum logic [2:0] {
    FRR_ST_RUN     = 3'b000,
    FRR_ST_GRACE   = 3'b001,
    FRR_ST_WAIT    = 3'b010,
    FRR_ST_RESTART = 3'b011,
    FRR_ST_LATCHED = 3'b100,
    FRR_ST_HOLD    = 3'b101
  } frr_state_e;
endpackage

// ==== hw/frr_delay_timer.sv ====
`timescale 1ns/1ns
`include "frr_params.svh"
module frr_delay_timer #(
  parameter int UNIT_CYC = `FRR_UNIT_CYC
) (
  input  wire logic        sys_clk,    // System clock
  input  wire logic        rstn,       // Async reset, active low
  input  wire logic        start,      // Load and begin timing
  input  wire logic        stop,       // Abort timing
  input  wire logic [2:0]  delay_code, // Power-of-two unit code
  input  wire logic [15:0] unit_mult,  // Unit length in base ticks
  output logic             expired     // One-cycle pulse at end
);
  logic [31:0] base_reg;
  logic [15:0] sub_reg;
  logic [7:0]  units_reg;
  logic        run_reg;
  wire         base_tick = (base_reg == 32'(UNIT_CYC - 1));
  wire         unit_tick = base_tick && (sub_reg + 16'h0001 >= unit_mult);
  wire         last_unit = (units_reg == 8'h01);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      base_reg  <= 32'h0000_0000;
      sub_reg   <= 16'h0000;
      units_reg <= 8'h00;
      run_reg   <= 1'b0;
      expired   <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        run_reg <= 1'b0;
      end else if (start) begin
        run_reg   <= 1'b1;
        base_reg  <= 32'h0000_0000;
        sub_reg   <= 16'h0000;
        units_reg <= 8'h01 << delay_code;
      end else if (run_reg) begin
        base_reg <= base_tick ? 32'h0000_0000 : base_reg + 32'h0000_0001;
        if (unit_tick) begin
          sub_reg <= 16'h0000;
          units_reg <= units_reg - 8'h01;
          if (last_unit) begin
            run_reg <= 1'b0;
            expired <= 1'b1;
          end
        end else if (base_tick) begin
          sub_reg <= sub_reg + 16'h0001;
        end
      end
    end
  end
endmodule // frr_delay_timer

// ==== hw/frr_core.sv ====
`timescale 1ns/1ns
`include "frr_params.svh"
module frr_core
  import frr_pkg::*;
#(
  parameter int UNIT_CYC = `FRR_UNIT_CYC
) (
  input  wire logic        sys_clk,       // System clock
  input  wire logic        rstn,          // Async reset, active low
  input  wire logic        cmd_wr,        // Register write strobe
  input  wire logic        cmd_rd,        // Register read strobe
  input  wire logic [7:0]  cmd_code,      // Command code
  input  wire logic [15:0] cmd_wdata,     // Write data
  output logic [15:0]      cmd_rdata,     // Read data, registered
  output logic             cmd_ack,       // Command code recognised
  input  wire logic        uv_fault,      // Under-voltage present
  input  wire logic        clear_faults,  // Clear-all-faults pulse
  input  wire logic        status_clear,  // Clear status bit pulse
  input  wire logic        output_cmd_on, // Output commanded on
  input  wire logic        bias_ok,       // Bias power good
  input  wire logic        other_shutdown,// Other fault shutdown
  output logic             output_enable, // Power stage enable
  output logic             fault_latched, // Latched fault status
  output logic [2:0]       attempt_count  // Restarts made so far
);
  import frr_pkg::*;

  logic [15:0] oc_limit_reg;
  logic [7:0]  uv_react_reg;
  logic [15:0] unit_reg;
  frr_state_e  state_reg;
  frr_state_e  state_next;
  logic        cmd_on_d_reg;
  logic        en_reg;

  // Only these states may leave the power stage switched on
  function automatic logic drives_output(input frr_state_e s);
    case (s)
      FRR_ST_RUN,
      FRR_ST_GRACE,
      FRR_ST_RESTART: drives_output = 1'b1;
      default:        drives_output = 1'b0;
    endcase
  endfunction

  function automatic logic timed_state(input frr_state_e s);
    timed_state = (s == FRR_ST_WAIT) || (s == FRR_ST_GRACE);
  endfunction

  // A zero unit is stored as one; the timer would time zero as one unit anyway
  function automatic logic [15:0] unit_fix(input logic [15:0] v);
    unit_fix = (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  wire frr_resp_e resp   =
    frr_resp_e'(uv_react_reg[`FRR_RESP_MSB:`FRR_RESP_LSB]);
  wire [2:0] retry_lim   = uv_react_reg[`FRR_RETRY_MSB:`FRR_RETRY_LSB];
  wire [2:0] delay_code  = uv_react_reg[`FRR_DELAY_MSB:`FRR_DELAY_LSB];
  wire       hit_oc      = (cmd_code == `FRR_CMD_OC_LIMIT);
  wire       hit_uv      = (cmd_code == `FRR_CMD_UV_REACT);
  wire       hit_unit    = (cmd_code == `FRR_CMD_UNIT);
  wire       reenable    = output_cmd_on && !cmd_on_d_reg;
  // Any of these drops the latch and restarts counting
  wire       clear_any   = clear_faults || status_clear || !bias_ok
                         || reenable;
  wire       stop_retry  = !output_cmd_on || !bias_ok || other_shutdown;
  wire       retry_left  = (retry_lim == `FRR_RETRY_FOREVER)
                         || (attempt_count < retry_lim);
  wire       timer_exp;
  wire       enter_wait  = (state_reg != FRR_ST_WAIT)
                         && (state_next == FRR_ST_WAIT);
  wire       enter_grace = (state_reg != FRR_ST_GRACE)
                         && (state_next == FRR_ST_GRACE);
  wire       timer_start = enter_wait || enter_grace;
  wire       timer_stop  = !timed_state(state_next);
  wire       wr_oc       = cmd_wr && hit_oc;
  wire       wr_uv       = cmd_wr && hit_uv;
  wire       wr_unit     = cmd_wr && hit_unit;
  wire       restart_go  = (state_next == FRR_ST_RESTART)
                         && (state_reg != FRR_ST_RESTART)
                         && (attempt_count != 3'h7);
  wire       next_on     = output_cmd_on && bias_ok
                         && drives_output(state_next);
  wire       next_latch  = (state_next == FRR_ST_LATCHED);

  function automatic frr_state_e after_fault(input logic more);
    after_fault = more ? FRR_ST_WAIT : FRR_ST_LATCHED;
  endfunction

  // Read mux
  wire [15:0] rd_sel = hit_oc   ? oc_limit_reg :
                       hit_uv   ? {8'h00, uv_react_reg} :
                       hit_unit ? unit_reg : 16'h0000;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FRR_ST_RUN: begin
        if (uv_fault) begin
          case (resp)
            FRR_RESP_CONTINUE: state_next = FRR_ST_GRACE;
            FRR_RESP_SHUTDOWN: state_next = after_fault(retry_left);
            FRR_RESP_HOLD:     state_next = FRR_ST_HOLD;
            default:           state_next = FRR_ST_RUN;
          endcase
        end
      end
      FRR_ST_GRACE: begin
        if (!uv_fault)
          state_next = FRR_ST_RUN;
        else if (timer_exp)
          state_next = after_fault(retry_left);
      end
      FRR_ST_WAIT: begin
        if (stop_retry)
          state_next = FRR_ST_LATCHED;
        else if (timer_exp)
          state_next = FRR_ST_RESTART;
      end
      FRR_ST_RESTART: begin
        // One cycle with output on; fault still there means failed try
        if (uv_fault)
          state_next = after_fault(retry_left);
        else
          state_next = FRR_ST_RUN;
      end
      FRR_ST_HOLD: begin
        if (!uv_fault)
          state_next = FRR_ST_RUN;
      end
      FRR_ST_LATCHED: begin
        if (clear_any)
          state_next = FRR_ST_RUN;
      end
      default: state_next = FRR_ST_RUN;
    endcase
    if (clear_any)
      state_next = FRR_ST_RUN;
  end

  frr_delay_timer #(.UNIT_CYC(UNIT_CYC)) u_timer (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .start      (timer_start),
    .stop       (timer_stop),
    .delay_code (delay_code),
    .unit_mult  (unit_reg),
    .expired    (timer_exp)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oc_limit_reg <= `FRR_OC_LIMIT_RST;
    end else if (wr_oc) begin
      oc_limit_reg <= cmd_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      uv_react_reg <= `FRR_UV_REACT_RST;
    end else if (wr_uv) begin
      uv_react_reg <= cmd_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      unit_reg <= `FRR_UNIT_RST;
    end else if (wr_unit) begin
      unit_reg <= unit_fix(cmd_wdata);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_rdata <= 16'h0000;
    end else if (cmd_rd) begin
      cmd_rdata <= rd_sel;
    end
  end

  assign cmd_ack = hit_oc || hit_uv || hit_unit;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FRR_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset as if already on, so release cannot fake a re-enable edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_on_d_reg <= 1'b1;
    end else begin
      cmd_on_d_reg <= output_cmd_on;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      attempt_count <= 3'h0;
    end else if (clear_any) begin
      attempt_count <= 3'h0;
    end else if (restart_go) begin
      attempt_count <= attempt_count + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= next_on;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_latched <= 1'b0;
    end else begin
      fault_latched <= next_latch;
    end
  end

  assign output_enable = en_reg;
endmodule // frr_core

// ==== verification/frr_core_assertions.sv ====
`timescale 1ns/1ns
module frr_core_assertions (
  input wire logic        sys_clk,       // Clock
  input wire logic        rstn,          // Reset
  input wire logic        cmd_wr,        // Write
  input wire logic        cmd_rd,        // Read
  input wire logic [7:0]  cmd_code,      // Code
  input wire logic [15:0] cmd_wdata,     // Wdata
  input wire logic [15:0] cmd_rdata,     // Rdata
  input wire logic        cmd_ack,       // Ack
  input wire logic        clear_faults,  // Clear
  input wire logic        output_cmd_on, // On
  input wire logic        bias_ok,       // Bias
  input wire logic        output_enable, // Enable
  input wire logic        fault_latched, // Latched
  input wire logic [2:0]  attempt_count  // Count
);
  logic [2:0] retry_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Shadow retry field; bench clears before rewriting it
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      retry_reg <= 3'h0;
    else if (cmd_wr && cmd_code == 8'h45)
      retry_reg <= cmd_wdata[5:3];
  property p_ack;
    cmd_ack == (cmd_code inside {8'h45, 8'h46, 8'hD2});
  endproperty
  property p_unk;
    cmd_rd && !cmd_ack |=> cmd_rdata == 16'h0000;
  endproperty
  property p_hold;
    !cmd_rd |=> $stable(cmd_rdata);
  endproperty
  property p_lim;
    retry_reg != 3'h7 |-> attempt_count <= retry_reg;
  endproperty
  property p_clr;
    clear_faults |=> attempt_count == 3'h0 && !fault_latched;
  endproperty
  property p_lat;
    fault_latched |-> !output_enable;
  endproperty
  property p_bias;
    !bias_ok |=> !output_enable;
  endproperty
  property p_step;
    $changed(attempt_count) |-> attempt_count == 3'h0
      || attempt_count == $past(attempt_count) + 3'h1;
  endproperty
  property p_on;
    $rose(output_enable) |-> $past(output_cmd_on && bias_ok);
  endproperty
  a_ack: assert property (p_ack) else $error("ack decode");
  a_unk: assert property (p_unk) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("rdata moved");
  a_lim: assert property (p_lim) else $error("too many");
  a_clr: assert property (p_clr) else $error("clear");
  a_lat: assert property (p_lat) else $error("latched on");
  a_bias: assert property (p_bias) else $error("bias");
  a_step: assert property (p_step) else $error("count step");
  a_on: assert property (p_on) else $error("enable cause");
  c_lat: cover property (fault_latched);
  c_sat: cover property (attempt_count == 3'h7);
  c_off: cover property ($fell(output_enable));
endmodule // frr_core_assertions
bind frr_core frr_core_assertions u_frr_core_assertions (
  .sys_clk(sys_clk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
  .cmd_ack(cmd_ack), .clear_faults(clear_faults),
  .output_cmd_on(output_cmd_on), .bias_ok(bias_ok),
  .output_enable(output_enable), .fault_latched(fault_latched),
  .attempt_count(attempt_count));

// ==== verification/frr_host_model.sv ====
`timescale 1ns/1ns
module frr_host_model (
  input  wire logic        sys_clk,   // Clock
  output logic             cmd_wr,    // Write strobe
  output logic             cmd_rd,    // Read strobe
  output logic [7:0]       cmd_code,  // Command code
  output logic [15:0]      cmd_wdata, // Write data
  input  wire logic [15:0] cmd_rdata  // Read data
);
  initial begin
    {cmd_wr, cmd_rd} = 2'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Idle data is inverted so stale values cannot pass
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge sys_clk);
    {cmd_code, cmd_wdata, cmd_wr} = {c, d, 1'b1};
    @(negedge sys_clk);
    {cmd_wdata, cmd_wr} = {~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(negedge sys_clk);
    {cmd_code, cmd_rd} = {c, 1'b1};
    @(negedge sys_clk);
    cmd_rd = 1'b0;
    d = cmd_rdata;
  endtask
endmodule // frr_host_model

// ==== verification/frr_core_tb.sv ====
`timescale 1ns/1ns
module frr_core_tb;
  logic        sys_clk, rstn, wr, rd, uv, clr, sclr, con, bias, oth;
  logic        oen, lat;
  logic [7:0]  code;
  logic [15:0] wd, rdat, v, lfsr;
  logic [2:0]  cnt;
  int          bad_count, check_count, t0, t1, i, d, u;
  frr_core #(.UNIT_CYC(2)) u_frr_core (.sys_clk(sys_clk), .rstn(rstn),
    .cmd_wr(wr), .cmd_rd(rd), .cmd_code(code), .cmd_wdata(wd),
    .cmd_rdata(rdat), .cmd_ack(), .uv_fault(uv), .clear_faults(clr),
    .status_clear(sclr), .output_cmd_on(con), .bias_ok(bias),
    .other_shutdown(oth), .output_enable(oen), .fault_latched(lat),
    .attempt_count(cnt));
  frr_host_model u_frr_host_model (.sys_clk(sys_clk), .cmd_wr(wr),
    .cmd_rd(rd), .cmd_code(code), .cmd_wdata(wd), .cmd_rdata(rdat));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Cycles per delay code at UNIT_CYC of 2
  function automatic int span(input int dc, input int un);
    return (1 << dc) * un * 2;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // 0 latched, 1 on, 2 off, else count equals k-3
  task automatic wt(input int k);
    for (int j = 0; j < 3000; j++) begin
      @(negedge sys_clk);
      if (k == 0 ? lat === 1'b1 : k == 1 ? oen === 1'b1 :
          k == 2 ? oen === 1'b0 : cnt === 3'(k - 3))
        return;
    end
    bad_count++;
    close_out;
  endtask
  task automatic clr_by(input int m);
    uv = 1'b0;
    case (m % 4)
      0: clr = 1'b1;
      1: sclr = 1'b1;
      2: con = 1'b0;
      default: bias = 1'b0;
    endcase
    @(negedge sys_clk);
    {clr, sclr, con, bias} = 4'b0011;
    repeat (2) @(negedge sys_clk);
    chk(16'({lat, cnt}), 16'h0000);
    wt(1);
  endtask
  task automatic gap(input logic [7:0] cfg, output int g);
    int s;
    u_frr_host_model.wr(8'h45, {8'h00, cfg});
    uv = 1'b1;
    if (!cfg[6])
      wt(4);
    s = int'($time);
    wt(cfg[6] ? 0 : 5);
    g = (int'($time) - s) / 8;
    wt(0);
    clr_by(0);
  endtask
  initial begin
    {rstn, uv, clr, sclr, con, bias, oth} = 7'b0000110;
    {bad_count, check_count, lfsr} = {32'd0, 32'd0, 16'd40921};
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    u_frr_host_model.rd(8'h45, v);
    chk(v, 16'h0080);
    u_frr_host_model.rd(8'h47, v);
    chk(v, 16'h0000);
    for (i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      u_frr_host_model.wr(8'h46, lfsr);
      u_frr_host_model.rd(8'h46, v);
      chk(v, lfsr);
    end
    u_frr_host_model.wr(8'hD2, 16'h0000);
    u_frr_host_model.rd(8'hD2, v);
    chk(v, 16'h0001);
    $display("test registers end");
    for (i = 2; i < 7; i++) begin
      u_frr_host_model.wr(8'h45, {10'h002, 3'(i), 3'h0});
      uv = 1'b1;
      wt(0);
      repeat (20) @(negedge sys_clk);
      chk(16'({oen, cnt}), 16'(i));
      clr_by(i);
    end
    $display("test retry counts end");
    for (i = 0; i < 2; i++) begin
      lfsr = nxt(lfsr);
      {u, d} = {32'(lfsr[0]) + 1, 32'(lfsr[2:1]) % 3};
      u_frr_host_model.wr(8'hD2, 16'(u));
      gap(i ? {5'h08, 3'(d)} : {5'h12, 3'(d)}, t0);
      gap(i ? {5'h08, 3'(d + 1)} : {5'h12, 3'(d + 1)}, t1);
      chk(16'(t1 - t0), 16'(span(d + 1, u) - span(d, u)));
    end
    $display("test timing end");
    u_frr_host_model.wr(8'h45, 16'h00B8);
    uv = 1'b1;
    wt(10);
    repeat (40) @(negedge sys_clk);
    chk(16'(lat), 16'h0000);
    oth = 1'b1;
    wt(0);
    oth = 1'b0;
    clr_by(0);
    u_frr_host_model.wr(8'h45, 16'h00C0);
    uv = 1'b1;
    wt(2);
    uv = 1'b0;
    wt(1);
    u_frr_host_model.wr(8'h45, 16'h0000);
    uv = 1'b1;
    repeat (30) @(negedge sys_clk);
    chk(16'({lat, oen}), 16'h0001);
    $display("test modes end");
    close_out;
  end
endmodule // frr_core_tb
